// ===== bench/ctb_trim_properties.sv
// checker for the trim bank: bus answer, fuse fetch and sample timing
// assumes it is bound onto ctb_trim_bank and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module ctb_trim_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ctb_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // fuse store and samples
  input wire logic fuse_rd,
  input wire logic [ctb_pkg::ENT_W-1:0] fuse_addr,
  input wire logic [ctb_pkg::NCORE-1:0][ctb_pkg::SAMP_W-1:0] core_sample,
  input wire logic [ctb_pkg::NCORE-1:0] core_sample_vld,
  input wire logic [ctb_pkg::NCORE-1:0][ctb_pkg::SAMP_W-1:0] core_trimmed,
  input wire logic [ctb_pkg::NCORE-1:0] core_trimmed_vld
);
  import ctb_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // fuse fetch steps: first word, then one word per cycle
  sequence s_first;
    fuse_rd && fuse_addr == 4'h0;
  endsequence
  sequence s_next;
    fuse_rd && fuse_addr == $past(fuse_addr) + 4'h1;
  endsequence
  a_fuse_start: assert property (
    $rose(rst_b) |-> ##[1:2] s_first)
    else $error("fuse fetch did not begin at word 0");
  a_fuse_step: assert property (
    fuse_rd && fuse_addr < LAST_ENT |=> s_next)
    else $error("fuse words not fetched in order");
  a_fuse_end: assert property (
    fuse_rd && fuse_addr == LAST_ENT |=> !fuse_rd)
    else $error("fuse fetch ran past the last word");
  a_no_ack_fetch: assert property (fuse_rd |-> !wb_ack_o)
    else $error("bus answered during fuse fetch");
  // ==========================================================
  // bus answer shape
  a_ack_cause: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  // a waiting request is answered, fuse fetch time included
  a_ack_bound: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##[1:16] wb_ack_o)
    else $error("request not answered in time");
  a_upper_zero: assert property (
    wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0)
    else $error("read data upper half not zero");
  a_unmapped_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i[11:2] < 10'h336
    |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  // ==========================================================
  // sample path timing and unsigned saturation
  a_vld_delay: assert property (
    $past(rst_b) |-> core_trimmed_vld == $past(core_sample_vld))
    else $error("trimmed valid not one cycle after input");
  a_sat_top: assert property (
    core_trimmed_vld[4] && $past(core_sample[4]) == 12'hfff
    |-> core_trimmed[4] == 12'hfff)
    else $error("full-scale sample not saturated");
endmodule
bind ctb_trim_bank ctb_trim_props u_props (
  .clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .fuse_rd(fuse_rd), .fuse_addr(fuse_addr),
  .core_sample(core_sample), .core_sample_vld(core_sample_vld),
  .core_trimmed(core_trimmed), .core_trimmed_vld(core_trimmed_vld));
`default_nettype wire

// ===== bench/tb.sv
// self-checking bench for the trim bank: fuse load, bus and sample path
// assumes the bench answers fuse reads and drives all other ports
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ctb_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dati = 32'h0, dato;
  logic ack, frd, s2 = 1'b0, s3 = 1'b0, byp = 1'b0;
  logic [3:0] fad;
  logic [15:0] fdat = 16'h0;
  logic [5:0][11:0] smp = '0, trm;
  logic [5:0] svld = 6'h0, tvld;
  logic [15:0] fuse [NREG];
  logic [15:0] tr [NREG];
  logic [31:0] rd_q [$];
  logic [71:0] sm_q [$];
  int n_fail = 0, checks_done = 0, cyc_cnt = 0, seed_v;
  logic [95:0] r;
  ctb_trim_bank u_dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dati), .wb_dat_o(dato), .wb_ack_o(ack), .fuse_rd(frd),
    .fuse_addr(fad), .fuse_data(fdat), .core2_sel_second_pair(s2),
    .core3_sel_fourth_pair(s3), .core_sample(smp),
    .core_sample_vld(svld), .core_trimmed(trm), .core_trimmed_vld(tvld));
  // ==========================================================
  // clock, fuse store answer and hang guard
  always #2.5 clk = ~clk;
  always @(posedge clk) if (frd) fdat <= fuse[fad];
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      n_fail++;
      finish_test();
    end
  end
  // monitor: oldest note is compared whenever a result appears
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      chk({40'h0, rd_q.pop_front()}, {40'h0, dato});
    end
    if (tvld === 6'h3f) begin
      chk(sm_q.pop_front(), trm);
    end
  end
  task automatic chk(input logic [71:0] e, input logic [71:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [9:0] ix, input logic [15:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    sel <= 4'h3;
    dati <= {16'h0, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] ix, input logic [31:0] e);
    rd_q.push_back(e);
    wb(1'b0, ix, 16'h0);
  endtask
  // saturating offset add then fine gain, all unsigned
  function automatic logic [11:0] trimf(input logic [11:0] s,
    input logic [11:0] o, input logic [4:0] g);
    logic [18:0] a;
    a = s + o;
    if (a > 19'hfff) a = 19'hfff;
    a = (a * (19'd32 + g)) >> 5;
    return (a > 19'hfff) ? 12'hfff : a[11:0];
  endfunction
  // one sample on every core, expectation from the trim model
  task automatic smpl(input logic [5:0][11:0] s, input logic p2,
    input logic p3);
    logic [5:0][11:0] e;
    e[0] = trimf(s[0], 12'h0, tr[E_GAIN_TRIM_CORE0][4:0]);
    e[1] = trimf(s[1], 12'h0, tr[E_GAIN_TRIM_CORE1][4:0]);
    e[2] = p2 ? trimf(s[2], tr[E_OFFSET_TRIM_CORE2_INPUT_B][11:0], tr[E_GAIN_TRIM_CORE2_INPUT_B][4:0])
              : trimf(s[2], 12'h0, tr[E_GAIN_TRIM_CORE2_INPUT_A][4:0]);
    e[3] = trimf(s[3], p3 ? tr[E_OFFSET_TRIM_CORE3_INPUT_D][11:0] : tr[E_OFFSET_TRIM_CORE3_INPUT_C][11:0], 5'h0);
    e[4] = trimf(s[4], tr[E_OFFSET_TRIM_CORE4][11:0], 5'h0);
    e[5] = trimf(s[5], tr[E_OFFSET_TRIM_CORE5][11:0], 5'h0);
    // bypass hands the raw sample through untouched
    if (byp) e = s;
    sm_q.push_back(e);
    @(posedge clk);
    smp <= s;
    svld <= 6'h3f;
    s2 <= p2;
    s3 <= p3;
    @(posedge clk);
    svld <= 6'h0;
  endtask
  task automatic do_rst();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    for (int k = 0; k < NREG; k++) tr[k] = fuse[k];
  endtask
  // ==========================================================
  // main sequence: two resets, fuse load, samples, writes, unmapped
  initial begin
    seed_v = $urandom(32'h58ea182c);
    for (int k = 0; k < NREG; k++) begin
      fuse[k] = 16'($urandom() % (IS_GAIN[k] ? 32 : 4096));
    end
    for (int p = 0; p < 2; p++) begin
      do_rst();
      for (int k = 0; k < NREG; k++) rd(TRIM_IDX[k], {16'h0, tr[k]});
      r = {$urandom(), $urandom(), $urandom()};
      smpl(r[71:0], p[0], p[0]);
      smpl({6{12'hfff}}, p[0], ~p[0]);
      for (int k = 0; k < NREG; k++) begin
        tr[k] = 16'($urandom() % (IS_GAIN[k] ? 32 : 4096));
        wb(1'b1, TRIM_IDX[k], tr[k]);
      end
      for (int k = 0; k < NREG; k++) rd(TRIM_IDX[k], {16'h0, tr[k]});
      for (int m = 0; m < 4; m++) begin
        r = {$urandom(), $urandom(), $urandom()};
        smpl(r[71:0], m[0], m[1]);
      end
    end
    wb(1'b1, 10'h100, 16'h1234);
    rd(10'h100, 32'h0);
    // bypass passes raw samples, then a reload brings fuse trims back
    wb(1'b1, IDX_TRIM_CTRL, 16'h0002);
    rd(IDX_TRIM_CTRL, 32'h2);
    byp = 1'b1;
    r = {$urandom(), $urandom(), $urandom()};
    smpl(r[71:0], 1'b1, 1'b0);
    wb(1'b1, IDX_TRIM_CTRL, 16'h0001);
    byp = 1'b0;
    for (int k = 0; k < NREG; k++) tr[k] = fuse[k];
    rd(IDX_TRIM_STATUS, 32'h1);
    for (int k = 0; k < NREG; k++) rd(TRIM_IDX[k], {16'h0, tr[k]});
    smpl({6{12'h800}}, 1'b1, 1'b1);
    repeat (3) @(posedge clk);
    // every noted result must have been seen
    chk(72'(rd_q.size() + sm_q.size()), 72'h0);
    finish_test();
  end
endmodule
`default_nettype wire

// ===== core/ctb_pkg.sv
// constants shared by the converter trim register bank
// assumes a 32-bit classic wishbone slave port and a 200 MHz clock
package ctb_pkg;

  // ==========================================================
  // sizes
  localparam int NREG = 9;
  localparam int NCORE = 6;
  localparam int OFS_W = 12;
  localparam int GAIN_W = 5;
  localparam int SAMP_W = 12;
  localparam int ADR_W = 12;
  localparam int IDX_W = 10;
  localparam int ENT_W = 4;
  localparam int GAIN_FRAC = 5;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [9:0] IDX_OFFSET_TRIM_CORE2_INPUT_B = 10'h336;
  localparam logic [9:0] IDX_OFFSET_TRIM_CORE3_INPUT_C = 10'h338;
  localparam logic [9:0] IDX_OFFSET_TRIM_CORE3_INPUT_D = 10'h33a;
  localparam logic [9:0] IDX_OFFSET_TRIM_CORE4 = 10'h33c;
  localparam logic [9:0] IDX_OFFSET_TRIM_CORE5 = 10'h33e;
  localparam logic [9:0] IDX_GAIN_TRIM_CORE0 = 10'h360;
  localparam logic [9:0] IDX_GAIN_TRIM_CORE1 = 10'h361;
  localparam logic [9:0] IDX_GAIN_TRIM_CORE2_INPUT_A = 10'h362;
  localparam logic [9:0] IDX_GAIN_TRIM_CORE2_INPUT_B = 10'h363;
  localparam logic [9:0] IDX_TRIM_CTRL = 10'h370;
  localparam logic [9:0] IDX_TRIM_STATUS = 10'h371;

  // entry order of the trim array, also the fuse word order
  localparam logic [9:0] TRIM_IDX [NREG] = '{
    IDX_OFFSET_TRIM_CORE2_INPUT_B, IDX_OFFSET_TRIM_CORE3_INPUT_C,
    IDX_OFFSET_TRIM_CORE3_INPUT_D, IDX_OFFSET_TRIM_CORE4,
    IDX_OFFSET_TRIM_CORE5, IDX_GAIN_TRIM_CORE0, IDX_GAIN_TRIM_CORE1,
    IDX_GAIN_TRIM_CORE2_INPUT_A, IDX_GAIN_TRIM_CORE2_INPUT_B};
  localparam logic [NREG-1:0] IS_GAIN = 9'h1e0;
  localparam int E_OFFSET_TRIM_CORE2_INPUT_B = 0;
  localparam int E_OFFSET_TRIM_CORE3_INPUT_C = 1;
  localparam int E_OFFSET_TRIM_CORE3_INPUT_D = 2;
  localparam int E_OFFSET_TRIM_CORE4 = 3;
  localparam int E_OFFSET_TRIM_CORE5 = 4;
  localparam int E_GAIN_TRIM_CORE0 = 5;
  localparam int E_GAIN_TRIM_CORE1 = 6;
  localparam int E_GAIN_TRIM_CORE2_INPUT_A = 7;
  localparam int E_GAIN_TRIM_CORE2_INPUT_B = 8;
  localparam logic [ENT_W-1:0] LAST_ENT = 4'h8;

  // ==========================================================
  // field layout and reset values
  localparam int OFS_LSB = 0;
  localparam int GAIN_LSB = 0;
  localparam logic [15:0] TRIM_RST = 16'h0000;
  localparam logic [OFS_W-1:0] OFS_NONE = 12'h000;
  localparam logic [GAIN_W-1:0] GAIN_NONE = 5'h00;
  localparam int CTRL_RELOAD = 0;
  localparam int CTRL_BYPASS = 1;
  localparam int STAT_LOADED = 0;
  localparam int STAT_LOADING = 1;

  // ==========================================================
  // control states, one-hot
  typedef enum logic [2:0] {
    ST_BOOT = 3'b001,
    ST_FETCH = 3'b010,
    ST_RUN = 3'b100
  } ctb_state_t;

endpackage

// ===== core/ctb_trim_apply.sv
// one core's sample path: unsigned offset add, then fine gain
// assumes samples arrive synchronous to clk with a valid strobe
`timescale 1ns/1ps
`default_nettype none
module ctb_trim_apply (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // trim values
  ctb_trim_if.path trim,
  // sample stream
  input wire logic [ctb_pkg::SAMP_W-1:0] sample_in,
  input wire logic sample_vld_in,
  output logic [ctb_pkg::SAMP_W-1:0] sample_out,
  output logic sample_vld_out
);
  import ctb_pkg::*;

  // ==========================================================
  // arithmetic
  localparam logic [SAMP_W:0] SAT_SUM = 13'h0fff;
  logic [SAMP_W:0] sum;
  logic [SAMP_W-1:0] sum_sat;
  logic [GAIN_W:0] gain_mul;
  logic [SAMP_W+GAIN_W:0] prod;
  logic [SAMP_W+GAIN_W-GAIN_FRAC:0] scaled;
  logic [SAMP_W-1:0] next_sample;

  // offset taken as unsigned, sum saturates at full scale
  assign sum = {1'b0, sample_in} + {1'b0, trim.offset}; // [RQ12]
  assign sum_sat = (sum > SAT_SUM) ? SAT_SUM[SAMP_W-1:0]
                                   : sum[SAMP_W-1:0];
  // gain is 1 + trim/32
  assign gain_mul = {1'b1, trim.gain};
  assign prod = {{(GAIN_W+1){1'b0}}, sum_sat} * {{SAMP_W{1'b0}}, gain_mul};
  assign scaled = prod[SAMP_W+GAIN_W:GAIN_FRAC];
  assign next_sample = trim.bypass ? sample_in
                     : (|scaled[SAMP_W+GAIN_W-GAIN_FRAC:SAMP_W])
                     ? SAT_SUM[SAMP_W-1:0] : scaled[SAMP_W-1:0];

  // output stage
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sample_out <= '0;
      sample_vld_out <= 1'b0;
    end else begin
      sample_out <= next_sample;
      sample_vld_out <= sample_vld_in;
    end
  end
endmodule
`default_nettype wire

// ===== core/ctb_trim_bank.sv
// converter trim register bank with its per-core sample paths
// assumes a classic wishbone master and a fuse store that answers one
// cycle after its read strobe
//
// What this block does
// [RQ1] core 2 uses the core-2 input-B offset word when sampling input B.
// [RQ2] core 3 uses the offset word at 0x338 when sampling input C.
// [RQ3] core 3 uses the offset word at 0x33A when sampling input D.
// [RQ4] core 4 uses the offset word bits 11:0 at 0x33C.
// [RQ5] core 5 uses the offset word bits 11:0 at 0x33E.
// [RQ6] core 0 uses the gain field bits 4:0 at 0x360.
// [RQ7] core 1 uses the gain field bits 4:0 at 0x361.
// [RQ8] core 2 uses the gain field at 0x362 when sampling input A.
// [RQ9] core 2 uses the gain field at 0x363 when sampling input B.
// [RQ10] software keeps reserved upper bits of every trim register zero.
// [RQ11] every trim register is loaded from fuse storage after reset.
// [RQ12] every offset trim word is treated as unsigned.
// [RQ13] software leaves offset trims alone during offset calibration.
// [RQ14] a trim write reaches the sample path with no reset needed.
//
// register map, byte address is four times the word index
//   0xcd8  offset trim, core 2 input B, bits 11:0, 15:12 reserved
//   0xce0  offset trim, core 3 input C
//   0xce8  offset trim, core 3 input D
//   0xcf0  offset trim, core 4
//   0xcf8  offset trim, core 5
//   0xd80  gain trim, core 0, bits 4:0, 7:5 reserved
//   0xd84  gain trim, core 1
//   0xd88  gain trim, core 2 input A
//   0xd8c  gain trim, core 2 input B
//   0xdc0  control, bit 0 reloads from fuses and reads 0, bit 1 bypass
//   0xdc4  status, bit 0 loaded, bit 1 fetch running
//   any other word reads zero and drops writes
//
// limits a user must know
//   no answer on the bus while the fuse fetch runs, about eleven
//   cycles after reset or a reload; a master just waits for ack
//   once running, the bank answers one cycle after a request
//   unmapped words answer too, so a stray access never hangs the bus
//   reserved bits are stored and read back but never reach a core
//   nothing stops a trim write during offset calibration
//   gain words keep only their low byte, sel[1] is ignored for them
//   trims reach the cores live, a write shows on the next sample
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module ctb_trim_bank (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ctb_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // fuse store
  output logic fuse_rd,
  output logic [ctb_pkg::ENT_W-1:0] fuse_addr,
  input wire logic [15:0] fuse_data,
  // input pair selection
  input wire logic core2_sel_second_pair,
  input wire logic core3_sel_fourth_pair,
  // raw samples, one slice per core
  input wire logic [ctb_pkg::NCORE-1:0][ctb_pkg::SAMP_W-1:0] core_sample,
  input wire logic [ctb_pkg::NCORE-1:0] core_sample_vld,
  // trimmed samples
  output logic [ctb_pkg::NCORE-1:0][ctb_pkg::SAMP_W-1:0] core_trimmed,
  output logic [ctb_pkg::NCORE-1:0] core_trimmed_vld
);
  import ctb_pkg::*;

  // ==========================================================
  // state
  // state of the fuse fetch sequencer
  ctb_state_t state;
  ctb_state_t next_state;
  // one 16-bit word per trim entry, in fuse word order
  logic [15:0] trim_q [NREG];
  // control and status bits
  logic bypass;
  logic loaded;
  // strobe delayed to meet the fuse answer
  logic fuse_rd_q;
  logic [ENT_W-1:0] fuse_addr_q;
  logic [ENT_W-1:0] next_fuse_addr;
  logic next_fuse_rd;

  // ==========================================================
  // bus decode
  // request qualification
  logic [IDX_W-1:0] word_idx;
  logic bus_req;
  logic run_st;
  logic next_ack;
  logic wr_fire;
  // address hits
  logic [NREG-1:0] hit;
  logic hit_ctrl;
  logic hit_stat;
  // read-back path
  logic [15:0] rd_chain [NREG+1];
  logic [31:0] rd_ctrl;
  logic [31:0] rd_stat;
  logic [31:0] rd_word;
  // control strobe and fetch end
  logic reload_req;
  logic fetch_last;

  // word index from the byte address, low two bits ignored
  assign word_idx = wb_adr_i[ADR_W-1:2];
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign run_st = (state == ST_RUN);
  // ack once per request, only while the bank is running
  // a request made during the fetch simply waits for it to end
  assign next_ack = bus_req & ~wb_ack_o & run_st;
  // a write lands at the edge where the master sees ack
  assign wr_fire = bus_req & wb_we_i & wb_ack_o;
  assign hit_ctrl = (word_idx == IDX_TRIM_CTRL);
  assign hit_stat = (word_idx == IDX_TRIM_STATUS);
  // reload request from the control register
  assign reload_req = wr_fire & hit_ctrl & wb_sel_i[0]
                    & wb_dat_i[CTRL_RELOAD];

  // per-entry hit and read-back chain
  // words never overlap, so or-ing the hit entries gives the one match
  assign rd_chain[0] = 16'h0000;
  for (genvar i = 0; i < NREG; i++) begin : g_dec
    assign hit[i] = (word_idx == TRIM_IDX[i]);
    assign rd_chain[i+1] = rd_chain[i]
                         | (hit[i] ? trim_q[i] : 16'h0000);
  end

  // own control and status words
  assign rd_ctrl = {30'h00000000, bypass, 1'b0};
  assign rd_stat = {30'h00000000, (state == ST_FETCH), loaded};
  // unmapped words read as zero
  assign rd_word = hit_ctrl ? rd_ctrl
                 : hit_stat ? rd_stat
                 : {16'h0000, rd_chain[NREG]};

  // ==========================================================
  // bus answer
  // ack is a one-cycle pulse; read data is registered with it and then
  // holds until the next answer, so a slow master still sees it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= next_ack;
      if (next_ack) begin
        wb_dat_o <= rd_word;
      end
    end
  end

  // ==========================================================
  // fuse fetch sequencer
  // fetch walk: the cycle after boot strobes word 0, then one word per
  // cycle up to the last entry; each answer is captured one cycle after
  // its strobe, and the bank runs once the last answer is in. a reload
  // from the control register walks the same path again.
  assign fetch_last = (fuse_addr == LAST_ENT);

  // next state and fuse strobe
  always_comb begin
    next_state = state;
    next_fuse_rd = 1'b0;
    next_fuse_addr = fuse_addr;
    case (state)
      ST_BOOT: begin
        // start again from the first fuse word
        next_state = ST_FETCH;
        next_fuse_rd = 1'b1;
        next_fuse_addr = '0;
      end
      ST_FETCH: begin
        // strobe words back to back until the last one
        if (fuse_rd && !fetch_last) begin
          next_fuse_rd = 1'b1;
          next_fuse_addr = fuse_addr + 4'h1;
        end
        // last answer captured, open the bus
        if (fuse_rd_q && fuse_addr_q == LAST_ENT) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        // software asked for a fresh fuse load
        if (reload_req) begin
          next_state = ST_BOOT;
        end
      end
      default: begin
        next_state = ST_BOOT;
      end
    endcase
  end

  // sequencer registers
  // reset parks the sequencer in boot, so a fetch follows every reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= ST_BOOT;
      fuse_rd <= 1'b0;
      fuse_addr <= '0;
    end else begin
      state <= next_state;
      fuse_rd <= next_fuse_rd;
      fuse_addr <= next_fuse_addr;
    end
  end

  // fuse answer follows the strobe by one cycle
  // the delayed strobe and word number pick the entry to load
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fuse_rd_q <= 1'b0;
      fuse_addr_q <= '0;
    end else begin
      fuse_rd_q <= fuse_rd;
      fuse_addr_q <= fuse_addr;
    end
  end

  // loaded flag, cleared while a fetch runs
  // the status word shows it next to the fetch-running bit
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      loaded <= 1'b0;
    end else if (state == ST_FETCH && next_state == ST_RUN) begin
      loaded <= 1'b1;
    end else if (state == ST_BOOT) begin
      loaded <= 1'b0;
    end
  end

  // ==========================================================
  // control register
  // bypass hands raw samples to every core; the reload bit is a strobe
  // and is never stored, so it reads back as zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bypass <= 1'b0;
    end else if (wr_fire && hit_ctrl && wb_sel_i[0]) begin
      bypass <= wb_dat_i[CTRL_BYPASS];
    end
  end

  // ==========================================================
  // trim registers, fuse load then software writes
  // a fuse answer overrides a bus write in the same cycle; the fetch only
  // runs while the bus is held off, so the two never meet in practice
  // gain entries ignore the upper byte lane, reserved bits 7:5 remain
  for (genvar i = 0; i < NREG; i++) begin : g_trim
    logic fuse_hit;
    logic wr_lo;
    logic wr_hi;
    assign fuse_hit = fuse_rd_q
                    & (fuse_addr_q == ENT_W'(i));
    assign wr_lo = wr_fire & hit[i] & wb_sel_i[0];
    assign wr_hi = wr_fire & hit[i] & wb_sel_i[1] & ~IS_GAIN[i];

    // fuse defaults first, then live software updates
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        trim_q[i] <= TRIM_RST;
      end else if (fuse_hit) begin
        trim_q[i] <= IS_GAIN[i] ? {8'h00, fuse_data[7:0]}
                                : fuse_data; // [RQ11]
      end else begin
        if (wr_lo) begin
          trim_q[i][7:0] <= wb_dat_i[7:0]; // [RQ14]
        end
        if (wr_hi) begin
          trim_q[i][15:8] <= wb_dat_i[15:8]; // [RQ14]
        end
      end
    end
  end

  // ==========================================================
  // per-core trim selection
  // each core sees only its own fields; cores without a gain or offset
  // register get a neutral value so one sample path serves them all
  logic [OFS_W-1:0] ofs_sel [NCORE];
  logic [GAIN_W-1:0] gain_sel [NCORE];

  // cores 0 and 1 carry gain only
  assign ofs_sel[0] = OFS_NONE;
  assign gain_sel[0] = trim_q[E_GAIN_TRIM_CORE0][GAIN_LSB +: GAIN_W]; // [RQ6]
  assign ofs_sel[1] = OFS_NONE;
  assign gain_sel[1] = trim_q[E_GAIN_TRIM_CORE1][GAIN_LSB +: GAIN_W]; // [RQ7]

  // core 2 follows its input pair
  // input A has no offset of its own here, it gets zero
  assign ofs_sel[2] = core2_sel_second_pair
                    ? trim_q[E_OFFSET_TRIM_CORE2_INPUT_B][OFS_LSB +: OFS_W] // [RQ1]
                    : OFS_NONE;
  assign gain_sel[2] = core2_sel_second_pair
                     ? trim_q[E_GAIN_TRIM_CORE2_INPUT_B][GAIN_LSB +: GAIN_W] // [RQ9]
                     : trim_q[E_GAIN_TRIM_CORE2_INPUT_A][GAIN_LSB +: GAIN_W]; // [RQ8]

  // core 3 picks the third or fourth pair offset
  // core 3 has no gain entry in this bank, it runs at unity
  assign ofs_sel[3] = core3_sel_fourth_pair
                    ? trim_q[E_OFFSET_TRIM_CORE3_INPUT_D][OFS_LSB +: OFS_W] // [RQ3]
                    : trim_q[E_OFFSET_TRIM_CORE3_INPUT_C][OFS_LSB +: OFS_W]; // [RQ2]
  assign gain_sel[3] = GAIN_NONE;

  // cores 4 and 5 carry offset only
  assign ofs_sel[4] = trim_q[E_OFFSET_TRIM_CORE4][OFS_LSB +: OFS_W]; // [RQ4]
  assign gain_sel[4] = GAIN_NONE;
  assign ofs_sel[5] = trim_q[E_OFFSET_TRIM_CORE5][OFS_LSB +: OFS_W]; // [RQ5]
  assign gain_sel[5] = GAIN_NONE;

  // ==========================================================
  // sample paths
  // one trim interface per core; the path registers its output, so
  // every trimmed sample and its valid leave the bank from flip-flops
  ctb_trim_if trim_link [NCORE] ();

  for (genvar c = 0; c < NCORE; c++) begin : g_core
    // live trims, no reset needed after a write
    assign trim_link[c].offset = ofs_sel[c]; // [RQ14]
    assign trim_link[c].gain = gain_sel[c];
    assign trim_link[c].bypass = bypass;

    ctb_trim_apply u_apply (
      .clk(clk),
      .rst_b(rst_b),
      .trim(trim_link[c]),
      .sample_in(core_sample[c]),
      .sample_vld_in(core_sample_vld[c]),
      .sample_out(core_trimmed[c]),
      .sample_vld_out(core_trimmed_vld[c])
    );
  end

endmodule
`default_nettype wire

// ===== core/ctb_trim_if.sv
// trim values handed from the register bank to one core's sample path
// assumes the bank drives each field from a register, a neutral constant or a pair-select mux
`timescale 1ns/1ps
`default_nettype none
interface ctb_trim_if;
  logic [ctb_pkg::OFS_W-1:0] offset;
  logic [ctb_pkg::GAIN_W-1:0] gain;
  logic bypass;
  modport bank (output offset, output gain, output bypass);
  modport path (input offset, input gain, input bypass);
endinterface
`default_nettype wire
